// >>> dbgst_avmm_slave.sv
// Avalon-MM slave front end: one wait cycle, registered read data and a write strobe
`timescale 1ns/100ps
`default_nettype none
`include "dbgst_cfg.svh"

module dbgst_avmm_slave
    import dbgst_pkg::*;
#(
    parameter int ADDR_W = `DBGST_ADDR_W,
    parameter int DATA_W = `DBGST_DATA_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Avalon-MM side
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DATA_W-1:0] avs_writedata_in,
    input wire logic [DATA_W/8-1:0] avs_byteenable_in,
    output logic [DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Register file side
    input wire logic [DATA_W-1:0] reg_rdata_in,
    output logic reg_wr_out,
    output logic [ADDR_W-1:0] reg_addr_out,
    output logic [DATA_W-1:0] reg_wdata_out,
    output logic [DATA_W/8-1:0] reg_be_out
);

    dbgst_bus_state_t state;
    dbgst_bus_state_t next_state;
    wire logic req = avs_read_in | avs_write_in;
    wire logic take = (state == DBGST_BUS_IDLE) && req;

    // Pass request fields straight to the register file
    assign reg_addr_out = avs_address_in;
    assign reg_wdata_out = avs_writedata_in;
    assign reg_be_out = avs_byteenable_in;
    // Write lands on the edge where the master sees waitrequest low
    assign reg_wr_out = (state == DBGST_BUS_ANSWER) && avs_write_in;

    // Next state
    always_comb begin
        case (state)
            DBGST_BUS_IDLE: next_state = take ? DBGST_BUS_ANSWER : DBGST_BUS_IDLE;
            DBGST_BUS_ANSWER: next_state = DBGST_BUS_IDLE;
            default: next_state = DBGST_BUS_IDLE;
        endcase
    end

    // State, waitrequest and read data registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= DBGST_BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= '0;
        end else begin
            state <= next_state;
            avs_waitrequest_out <= !take;
            if (take && avs_read_in) begin
                avs_readdata_out <= reg_rdata_in;
            end
        end
    end

endmodule
`default_nettype wire

// >>> dbgst_cfg.svh
// Offsets, field positions, reset values and codes of the debugger status block
`ifndef DBGST_CFG_SVH
`define DBGST_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DBGST_ADDR_W 4
`define DBGST_OFS_CONTROL 4'h0
`define DBGST_OFS_STATUS 4'h4

// ----------------------------------------------------------------
// Debug control register fields
// ----------------------------------------------------------------
`define DBGST_CTL_MODE_BIT 7
`define DBGST_CTL_BREAKPOINT_ENABLE_CONTROL_BIT 6
`define DBGST_CTL_ACK_BIT 5
`define DBGST_CTL_RST_BIT 0
`define DBGST_CTL_RESET 8'h00

// ----------------------------------------------------------------
// Debugger status register fields
// ----------------------------------------------------------------
`define DBGST_STAT_DEBUG_BIT 7
`define DBGST_STAT_HALT_BIT 6
`define DBGST_STAT_BYPASS_BIT 5
`define DBGST_STAT_RSVD_HI 4
`define DBGST_STAT_RSVD_LO 0
`define DBGST_STAT_RSVD_VAL 5'h00
`define DBGST_STAT_RESET 8'h00

// ----------------------------------------------------------------
// Bus widths and fixed answers
// ----------------------------------------------------------------
`define DBGST_DATA_W 32
`define DBGST_REG_W 8
`define DBGST_BE_W 4
`define DBGST_UNMAPPED_RDATA 32'h0000_0000
`define DBGST_ACK_CHAR 8'hff

`endif

// >>> dbgst_cpu_model.sv
// Processor and flash option model that feeds the debugger status block
`timescale 1ns/100ps
`default_nettype none
module dbgst_cpu_model (
    // Clock and requested state
    input wire logic clk_in,
    input wire logic [3:0] state_in,
    // Processor state and flash options
    output logic bp_out,
    output logic halt_out,
    output logic prot_out,
    output logic byp_out
);
    // Levels and the breakpoint pulse follow the request one cycle later
    always_ff @(posedge clk_in) begin
        {bp_out, halt_out, prot_out, byp_out} <= state_in;
    end
endmodule
`default_nettype wire

// >>> dbgst_pkg.sv
// Types shared by the debugger status block
package dbgst_pkg;

    // Bus answer states, Gray coded along idle -> answer
    typedef enum logic [1:0] {
        DBGST_BUS_IDLE = 2'b00,
        DBGST_BUS_ANSWER = 2'b01
    } dbgst_bus_state_t;

endpackage

// >>> dbgst_properties.sv
// Concurrent checks on the ports of the debugger status block
`timescale 1ns/100ps
`default_nettype none
module dbgst_props #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 32,
    parameter int REG_W = 8
) (
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DATA_W-1:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Processor side
    input wire logic flash_read_protect_option_in,
    input wire logic read_protect_bypass_flag_in,
    input wire logic fetch_stall_out,
    input wire logic restart_out,
    input wire logic command_restrict_out,
    input wire logic debug_ack_out,
    input wire logic [REG_W-1:0] debug_ack_char_out
);
    logic prot_q;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Restriction seen by the bus one cycle ago
    always_ff @(posedge clk_in) begin
        prot_q <= flash_read_protect_option_in && !read_protect_bypass_flag_in;
    end
    a_answer_next: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer late");
    a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer longer than one cycle");
    a_reserved_zero: assert property (avs_read_in && avs_waitrequest_out && avs_address_in == 4'h4
        |=> avs_readdata_out[4:0] == 5'h00) else $error("reserved status bits set");
    a_restrict_level: assert property (!$past(sys_rst_in) |-> command_restrict_out == prot_q)
        else $error("restriction wrong");
    a_locked_debug: assert property (fetch_stall_out && flash_read_protect_option_in && !read_protect_bypass_flag_in
        |=> fetch_stall_out) else $error("debug mode left under protection");
    a_restart_fall: assert property ($fell(fetch_stall_out) && !$past(sys_rst_in) |-> ##[0:1] restart_out)
        else $error("no restart pulse");
    a_restart_once: assert property (restart_out |-> !fetch_stall_out ##1 !restart_out)
        else $error("restart pulse wrong");
    a_ack_char: assert property (debug_ack_char_out == (debug_ack_out ? 8'hff : 8'h00))
        else $error("ack character wrong");
    a_ack_halts: assert property (debug_ack_out |-> ##[0:2] fetch_stall_out)
        else $error("breakpoint did not stall");
endmodule
bind dbgst_top dbgst_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .REG_W(REG_W)) dbgst_props_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .flash_read_protect_option_in(flash_read_protect_option_in),
    .read_protect_bypass_flag_in(read_protect_bypass_flag_in),
    .fetch_stall_out(fetch_stall_out),
    .restart_out(restart_out),
    .command_restrict_out(command_restrict_out),
    .debug_ack_out(debug_ack_out),
    .debug_ack_char_out(debug_ack_char_out)
);
`default_nettype wire

// >>> dbgst_status_reg.sv
// Debugger status register: captures processor and protection state every cycle
`timescale 1ns/100ps
`default_nettype none
`include "dbgst_cfg.svh"

module dbgst_status_reg
    import dbgst_pkg::*;
#(
    parameter int REG_W = `DBGST_REG_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Live state
    input wire logic debug_mode_in,
    input wire logic halt_state_in,
    input wire logic protect_bypass_in,
    // Register value
    output logic [REG_W-1:0] status_out
);

    logic [REG_W-1:0] next_status;

    // Assemble the live value; software has no write path here
    always_comb begin
        next_status = `DBGST_STAT_RESET;
        next_status[`DBGST_STAT_DEBUG_BIT] = debug_mode_in;
        next_status[`DBGST_STAT_HALT_BIT] = halt_state_in;
        next_status[`DBGST_STAT_BYPASS_BIT] = protect_bypass_in;
        next_status[`DBGST_STAT_RSVD_HI:`DBGST_STAT_RSVD_LO] = `DBGST_STAT_RSVD_VAL;
    end

    // Zero after reset, then tracks state
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            status_out <= `DBGST_STAT_RESET;
        end else begin
            status_out <= next_status;
        end
    end

endmodule
`default_nettype wire

// >>> dbgst_top.sv
// What this block does
// - Status bit 7 reads 1 in debug mode, 0 in normal mode.
// - Status bit 6 reads 1 while the processor sits in halt mode.
// - Status bit 5 reads 0 when read protect can restrict commands, else 1.
// - Bypassing read protect lifts all command restriction; bit 5 shows it.
// - Status bits 4 to 0 always read as zero.
// - Enabled breakpoint instruction sets debug mode; fetching stops while set.
// - Clearing debug mode restarts; under read protect only reset clears it.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dbgst_cfg.svh"

module dbgst_top
    import dbgst_pkg::*;
#(
    parameter int ADDR_W = `DBGST_ADDR_W,
    parameter int DATA_W = `DBGST_DATA_W,
    parameter int REG_W = `DBGST_REG_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Avalon-MM register bus
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DATA_W-1:0] avs_writedata_in,
    input wire logic [DATA_W/8-1:0] avs_byteenable_in,
    output logic [DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Processor state
    input wire logic breakpoint_instruction_in,
    input wire logic halt_state_in,
    // Flash protection options
    input wire logic flash_read_protect_option_in,
    input wire logic read_protect_bypass_flag_in,
    // Processor and debugger controls
    output logic fetch_stall_out,
    output logic restart_out,
    output logic command_restrict_out,
    output logic debug_ack_out,
    output logic [REG_W-1:0] debug_ack_char_out,
    output logic device_reset_req_out
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic reg_wr;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W/8-1:0] reg_be;
    logic [DATA_W-1:0] reg_rdata;
    logic [REG_W-1:0] status;
    logic debug_mode_control;
    logic breakpoint_enable_control;
    logic debug_ack_enable;
    logic next_debug_mode_control;
    logic next_breakpoint_enable_control;
    logic next_debug_ack_enable;

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    dbgst_avmm_slave #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_slave (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .reg_rdata_in(reg_rdata),
        .reg_wr_out(reg_wr),
        .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata),
        .reg_be_out(reg_be)
    );

    // ----------------------------------------------------------------
    // Protection and decode
    // ----------------------------------------------------------------

    // Protect only counts while it is not bypassed
    wire logic protect_bypassed = read_protect_bypass_flag_in || !flash_read_protect_option_in;
    wire logic protect_active = !protect_bypassed;
    // Address decode; status has no write select at all
    wire logic sel_control = (reg_addr == `DBGST_OFS_CONTROL);
    wire logic sel_status = (reg_addr == `DBGST_OFS_STATUS);
    wire logic ctl_wr = reg_wr && sel_control && reg_be[0];
    wire logic [REG_W-1:0] ctl_wbyte = reg_wdata[REG_W-1:0];
    // Breakpoint hit only counts when breakpoints are enabled
    wire logic bp_hit = breakpoint_instruction_in && breakpoint_enable_control;
    // Software clear of debug mode, refused under active protect
    wire logic mode_clear_req = ctl_wr && !ctl_wbyte[`DBGST_CTL_MODE_BIT];
    wire logic mode_clear_ok = mode_clear_req && !protect_active;
    wire logic mode_set_req = ctl_wr && ctl_wbyte[`DBGST_CTL_MODE_BIT];
    wire logic reset_req = ctl_wr && ctl_wbyte[`DBGST_CTL_RST_BIT];
    wire logic [REG_W-1:0] control_view = {debug_mode_control, breakpoint_enable_control, debug_ack_enable,
                                          {(REG_W-3){1'b0}}};

    // Read mux, unmapped addresses read zero
    assign reg_rdata = sel_control ? {{(DATA_W-REG_W){1'b0}}, control_view} :
                       sel_status ? {{(DATA_W-REG_W){1'b0}}, status} :
                       `DBGST_UNMAPPED_RDATA;

    // ----------------------------------------------------------------
    // Debug control next values
    // ----------------------------------------------------------------

    // Breakpoint set wins over a clear in the same cycle
    always_comb begin
        next_debug_mode_control = debug_mode_control;
        if (bp_hit || mode_set_req) begin
            next_debug_mode_control = 1'b1;
        end else if (mode_clear_ok) begin
            next_debug_mode_control = 1'b0;
        end
        next_breakpoint_enable_control = ctl_wr ? ctl_wbyte[`DBGST_CTL_BREAKPOINT_ENABLE_CONTROL_BIT] : breakpoint_enable_control;
        next_debug_ack_enable = ctl_wr ? ctl_wbyte[`DBGST_CTL_ACK_BIT] : debug_ack_enable;
    end

    // Control register flops
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            debug_mode_control <= 1'(`DBGST_CTL_RESET >> `DBGST_CTL_MODE_BIT);
            breakpoint_enable_control <= 1'b0;
            debug_ack_enable <= 1'b0;
        end else begin
            debug_mode_control <= next_debug_mode_control;
            breakpoint_enable_control <= next_breakpoint_enable_control;
            debug_ack_enable <= next_debug_ack_enable;
        end
    end

    // ----------------------------------------------------------------
    // Processor and debugger outputs
    // ----------------------------------------------------------------

    // All outputs registered; stall and restart from the next debug mode value, the rest from current values
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fetch_stall_out <= 1'b0;
            restart_out <= 1'b0;
            command_restrict_out <= 1'b0;
            debug_ack_out <= 1'b0;
            debug_ack_char_out <= '0;
            device_reset_req_out <= 1'b0;
        end else begin
            fetch_stall_out <= next_debug_mode_control;
            restart_out <= debug_mode_control && !next_debug_mode_control;
            command_restrict_out <= protect_active;
            debug_ack_out <= bp_hit && debug_ack_enable;
            debug_ack_char_out <= (bp_hit && debug_ack_enable) ? `DBGST_ACK_CHAR : '0;
            device_reset_req_out <= reset_req;
        end
    end

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    dbgst_status_reg #(
        .REG_W(REG_W)
    ) u_status (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .debug_mode_in(debug_mode_control),
        .halt_state_in(halt_state_in),
        .protect_bypass_in(protect_bypassed),
        .status_out(status)
    );

endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the debugger status block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [3:0] cpu_cmd = 4'h2;
    logic bp, halt, prot, byp, fetch_stall_out, dbg;
    logic restart, cmd_restrict, ack, rst_req;
    logic [7:0] ack_char;
    logic [7:0] ack_seen = 8'h00;
    int n_restart = 0;
    int n_ack = 0;
    int n_rstreq = 0;
    int n_fall = 0;
    logic [31:0] q, r;
    logic [31:0] seed = 32'h54981901;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;

    always #5 clk_in = ~clk_in;

    dbgst_cpu_model dbgst_cpu_model_i (.clk_in(clk_in), .state_in(cpu_cmd), .bp_out(bp), .halt_out(halt),
        .prot_out(prot), .byp_out(byp));
    dbgst_top dbgst_top_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .breakpoint_instruction_in(bp), .halt_state_in(halt), .flash_read_protect_option_in(prot),
        .read_protect_bypass_flag_in(byp), .fetch_stall_out(fetch_stall_out), .restart_out(restart),
        .command_restrict_out(cmd_restrict), .debug_ack_out(ack), .debug_ack_char_out(ack_char),
        .device_reset_req_out(rst_req));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Status value from debug, halt, protect and bypass
    function automatic logic [31:0] stat_exp(input logic d, input logic h, input logic p, input logic b);
        return {24'h0, d, h, b | ~p, 5'h00};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer; read data lands in q
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= ~we;
        avs_write_in <= we;
        // Wait until waitrequest goes low; the hang guard ends a stuck wait
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic close_out();
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Count one-cycle pulses on the debugger outputs
    always @(posedge clk_in) begin
        if (restart === 1'b1) n_restart++;
        if (rst_req === 1'b1) n_rstreq++;
        if (ack === 1'b1) begin
            n_ack++;
            ack_seen = ack_char;
        end
    end

    // Hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end

    // Pulse the breakpoint input with bypass on
    task automatic breakpoint_instruction();
        cpu_cmd <= 4'h9;
        tick(1);
        cpu_cmd <= 4'h1;
        tick(4);
    endtask

    initial begin
        tick(8);
        sys_rst_in <= 1'b0;
        tick(1);
        bus(0, 4'h4, 0);
        check(q, 32'h0);
        dbg = 1'b0;
        for (int i = 0; i < 12; i++) begin
            r = xs();
            cpu_cmd <= {1'b0, r[2:0]};
            tick(3);
            if (dbg && !r[3] && !(r[1] & ~r[0])) n_fall++;
            dbg = r[3] | (dbg & r[1] & ~r[0]);
            bus(1, 4'h0, {24'h0, r[3], 7'h0});
            tick(3);
            bus(0, 4'h4, 0);
            check(q, stat_exp(dbg, r[2], r[1], r[0]));
            bus(1, 4'h4, r);
            bus(0, 4'h4, 0);
            check(q, stat_exp(dbg, r[2], r[1], r[0]));
            check(fetch_stall_out, dbg);
            check(cmd_restrict, r[1] & ~r[0]);
            bus(0, {2'b10, r[5:4]}, 0);
            check(q, 32'h0);
        end
        cpu_cmd <= 4'h1;
        tick(3);
        if (dbg) n_fall++;
        bus(1, 4'h0, 32'h0);
        breakpoint_instruction();
        check(fetch_stall_out, 1'b0);
        bus(1, 4'h0, 32'h60);
        breakpoint_instruction();
        check(fetch_stall_out, 1'b1);
        bus(0, 4'h4, 0);
        check(q, 32'ha0);
        cpu_cmd <= 4'h2;
        tick(3);
        bus(1, 4'h0, 32'h0);
        tick(3);
        check(fetch_stall_out, 1'b1);
        // Mid-run reset is the only way out of debug mode under protection
        sys_rst_in <= 1'b1;
        tick(2);
        sys_rst_in <= 1'b0;
        tick(1);
        check(fetch_stall_out, 1'b0);
        bus(0, 4'h4, 0);
        check(q, 32'h0);
        bus(1, 4'h0, 32'h80);
        cpu_cmd <= 4'h3;
        tick(3);
        bus(1, 4'h0, 32'h0);
        tick(3);
        check(fetch_stall_out, 1'b0);
        n_fall++;
        bus(1, 4'h0, 32'h1);
        tick(4);
        check(n_restart, n_fall);
        check(n_rstreq, 1);
        check(n_ack, 1);
        check(ack_seen, 8'hff);
        close_out();
    end
endmodule
`default_nettype wire
